// ==== dv/tcic_evt_src.sv ====
// Event source model driving the capture pin, comparator output and external clock
`default_nettype none
module tcic_evt_src
(
  input  wire logic i_clk,
  output logic      o_cap_pin,
  output logic      o_cmp_out,
  output logic      o_ext_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_cap_pin = 1'b0;
    o_cmp_out = 1'b0;
    o_ext_clk = 1'b0;
  end

  // Full clock periods, four system cycles per phase so the synchroniser sees each
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge i_clk);
      o_ext_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_ext_clk <= 1'b0;
    end
  endtask

  task automatic set_cap(input logic v);
    @(posedge i_clk);
    o_cap_pin <= v;
  endtask

  task automatic set_cmp(input logic v);
    @(posedge i_clk);
    o_cmp_out <= v;
  endtask
endmodule // tcic_evt_src
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the sixteen-bit timer counter with input capture
`default_nettype none
`include "tcic_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       rst;
  logic [2:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [3:0] presc;
  logic       port_out;
  logic       port_oe;
  logic       cmp_sel;
  logic       cap_ack;
  logic       ovf_ack;
  logic [7:0] rdata;
  logic       ovf_irq;
  logic       cap_irq;
  logic       at_top;
  logic       at_bot;
  logic       cap_pin;
  logic       cmp_out;
  logic       ext_clk;
  int         fails           = 0;
  int         samples_checked = 0;

  always #12.5 clk = ~clk;

  tcic_top dut
  (
    .I_SYS_CLK        (clk),
    .I_RST            (rst),
    .I_ADDR           (addr),
    .I_WR             (wr),
    .I_RD             (rd),
    .I_WDATA          (wdata),
    .O_RDATA          (rdata),
    .I_PRESC_TICK     (presc),
    .I_EXT_CLK_PIN    (ext_clk),
    .I_CAP_PIN        (cap_pin),
    .I_CAP_PORT_OUT   (port_out),
    .I_CAP_PORT_OE    (port_oe),
    .I_CMP_OUT        (cmp_out),
    .I_CMP_CAPTURE_SEL(cmp_sel),
    .I_OVF_IRQ_ACK    (ovf_ack),
    .I_CAP_IRQ_ACK    (cap_ack),
    .O_OVF_IRQ        (ovf_irq),
    .O_CAP_IRQ        (cap_irq),
    .O_AT_TOP         (at_top),
    .O_AT_REACHED_A      (at_bot)
  );

  tcic_evt_src ev (.i_clk(clk), .o_cap_pin(cap_pin), .o_cmp_out(cmp_out), .o_ext_clk(ext_clk));

  // ==========================================================================
  // Reporting and bus tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if ((fails == 0) && (samples_checked > 0))
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr8(a + 3'h1, v[15:8]);
    wr8(a, v[7:0]);
    #1;
  endtask

  task automatic rd16(input logic [2:0] a, output logic [15:0] v);
    rd8(a, v[7:0]);
    rd8(a + 3'h1, v[15:8]);
  endtask

  task automatic wait_irq(input logic ovf, input int lim, output int n);
    n = 0;
    while (((ovf ? ovf_irq : cap_irq) !== 1'b1) && (n < lim))
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      test_done();
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [15:0] v;
    #1;
    check(16'({at_top, at_bot, ovf_irq, cap_irq}), 16'h0004);
    rd16(`TCIC_A_CAP_LO, v);
    check(v, 16'h0000);
    rd8(`TCIC_A_FLAG, v[7:0]);
    check(v, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [15:0] v;
    wr16(`TCIC_A_CNT_LO, 16'h01ff);
    repeat (5) @(posedge clk);
    rd16(`TCIC_A_CNT_LO, v);
    check(v, 16'h01ff);
    wr8(`TCIC_A_CNT_HI, 8'h7e);
    rd16(`TCIC_A_CNT_LO, v);
    check(v, 16'h01ff);
    wr8(`TCIC_A_CAP_HI, 8'h3c);
    wr8(`TCIC_A_CNT_LO, 8'h22);
    rd16(`TCIC_A_CNT_LO, v);
    check(v, 16'h3c22);
    wr16(`TCIC_A_CAP_LO, 16'h5555);
    rd16(`TCIC_A_CAP_LO, v);
    check(v, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_clock_sel();
    logic [7:0] b;
    for (int cs = 2; cs < 8; cs++)
    begin
      wr16(`TCIC_A_CNT_LO, 16'h0000);
      wr8(`TCIC_A_CTRL_B, 8'(cs));
      if (cs < 6)
        repeat (3)
        begin
          @(posedge clk);
          presc <= 4'(1 << (cs - 2));
          @(posedge clk);
          presc <= ~4'(1 << (cs - 2));
          @(posedge clk);
          presc <= 4'h0;
        end
      else
        ev.ext_pulses(3);
      repeat (6) @(posedge clk);
      wr8(`TCIC_A_CTRL_B, 8'h00);
      rd8(`TCIC_A_CNT_LO, b);
      check(16'(b), 16'h0003);
    end
    $display("test clock select done");
  endtask

  task automatic t_count();
    logic [7:0] b;
    int         n;
    wr8(`TCIC_A_MASK, 8'h21);
    rd8(`TCIC_A_MASK, b);
    check(16'(b), 16'h0021);
    wr8(`TCIC_A_CTRL_B, 8'h01);
    wr16(`TCIC_A_CNT_LO, 16'h1234);
    rd8(`TCIC_A_CNT_LO, b);
    check(16'(b), 16'h0035);
    wr8(`TCIC_A_CTRL_B, 8'h00);
    wr16(`TCIC_A_CNT_LO, 16'hffff);
    check(16'({at_top, at_bot, ovf_irq}), 16'h0004);
    wr8(`TCIC_A_CTRL_B, 8'h01);
    wait_irq(1'b1, 8, n);
    wr8(`TCIC_A_CTRL_B, 8'h00);
    wr8(`TCIC_A_FLAG, 8'h01);
    #1;
    check(16'(ovf_irq), 16'h0000);
    $display("test count done");
  endtask

  task automatic t_capture();
    logic [15:0] v;
    int          n0;
    int          n1;
    wr8(`TCIC_A_CTRL_B, 8'h40);
    wr16(`TCIC_A_CNT_LO, 16'h0a5c);
    wr8(`TCIC_A_FLAG, 8'h21);
    ev.set_cap(1'b1);
    wait_irq(1'b0, 12, n0);
    @(posedge clk);
    cap_ack <= 1'b1;
    @(posedge clk);
    cap_ack <= 1'b0;
    #1;
    check(16'(cap_irq), 16'h0000);
    ev.set_cap(1'b0);
    repeat (8) @(posedge clk);
    #1;
    check(16'(cap_irq), 16'h0000);
    wr16(`TCIC_A_CNT_LO, 16'h0bcd);
    ev.set_cap(1'b1);
    wait_irq(1'b0, 12, n0);
    rd16(`TCIC_A_CAP_LO, v);
    check(v, 16'h0bcd);
    wr8(`TCIC_A_FLAG, 8'h20);
    #1;
    check(16'(cap_irq), 16'h0000);
    wr8(`TCIC_A_CTRL_B, 8'hc0);
    ev.set_cap(1'b0);
    repeat (10) @(posedge clk);
    ev.set_cap(1'b1);
    ev.set_cap(1'b0);
    repeat (12) @(posedge clk);
    #1;
    check(16'(cap_irq), 16'h0000);
    ev.set_cap(1'b1);
    wait_irq(1'b0, 20, n1);
    check(16'(n1), 16'(n0 + 4));
    $display("test capture done");
  endtask

  task automatic t_source();
    int n;
    wr8(`TCIC_A_CTRL_B, 8'h40);
    ev.set_cap(1'b0);
    repeat (6) @(posedge clk);
    wr8(`TCIC_A_FLAG, 8'h21);
    port_oe <= 1'b1;
    @(posedge clk);
    port_out <= 1'b1;
    wait_irq(1'b0, 12, n);
    @(posedge clk);
    port_oe  <= 1'b0;
    port_out <= 1'b0;
    @(posedge clk);
    cmp_sel <= 1'b1;
    repeat (6) @(posedge clk);
    wr8(`TCIC_A_FLAG, 8'h21);
    ev.set_cmp(1'b1);
    wait_irq(1'b0, 12, n);
    @(posedge clk);
    cmp_sel <= 1'b0;
    $display("test source done");
  endtask

  task automatic t_dual();
    logic [15:0] v;
    int          n;
    ev.set_cap(1'b0);
    wr8(`TCIC_A_CTRL_A, 8'h02);
    wr8(`TCIC_A_CTRL_B, 8'h10);
    wr16(`TCIC_A_CAP_LO, 16'h0010);
    rd16(`TCIC_A_CAP_LO, v);
    check(v, 16'h0010);
    wr16(`TCIC_A_CNT_LO, 16'h0010);
    check(16'(at_top), 16'h0001);
    wr8(`TCIC_A_FLAG, 8'h21);
    wr8(`TCIC_A_CTRL_B, 8'h51);
    rd16(`TCIC_A_CNT_LO, v);
    check(v, 16'h000f);
    ev.set_cap(1'b1);
    repeat (10) @(posedge clk);
    #1;
    check(16'(cap_irq), 16'h0000);
    wait_irq(1'b1, 40, n);
    @(posedge clk);
    ovf_ack <= 1'b1;
    @(posedge clk);
    ovf_ack <= 1'b0;
    #1;
    check(16'(ovf_irq), 16'h0000);
    $display("test dual slope done");
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    clk      = 1'b0;
    rst      = 1'b1;
    addr     = 3'h0;
    wr       = 1'b0;
    rd       = 1'b0;
    wdata    = 8'h00;
    presc    = 4'h0;
    port_out = 1'b0;
    port_oe  = 1'b0;
    cmp_sel  = 1'b0;
    cap_ack  = 1'b0;
    ovf_ack  = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_clock_sel();
    t_count();
    t_capture();
    t_source();
    t_dual();
    test_done();
  end
endmodule // testbench
`default_nettype wire

// ==== rtl/tcic_capfilt.sv ====
// Capture trigger path: synchronisers, source select, noise filter, edge detect
`default_nettype none
`include "tcic_params.svh"
module tcic_capfilt
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  input  wire logic i_cmp,
  input  wire logic i_cmp_sel,
  tcic_evt_if.cap_src evt
);
  logic [1:0] pin_sync_q;
  logic [1:0] cmp_sync_q;
  logic [2:0] smp_q;
  logic       filt_q;
  logic       prev_q;
  logic       src;
  logic       lvl;

  // =====================================================================
  // Synchronisers, sample history and filtered level
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pin_sync_q <= 2'h0;
      cmp_sync_q <= 2'h0;
      smp_q      <= 3'h0;
      filt_q     <= 1'b0;
      prev_q     <= 1'b0;
    end
    else
    begin
      pin_sync_q <= {pin_sync_q[0], i_pin};
      cmp_sync_q <= {cmp_sync_q[0], i_cmp};
      smp_q      <= {smp_q[1:0], src}; // (R19)
      if ({smp_q, src} == {`TCIC_FILT_SMP{src}})
        filt_q <= src; // (R18)
      prev_q     <= lvl;
    end
  end

  assign src = i_cmp_sel ? cmp_sync_q[1] : pin_sync_q[1]; // (R16)
  assign lvl = evt.filt_en ? filt_q : src; // (R17)

  // =====================================================================
  // Edge detector
  always_comb
  begin
    if (!evt.armed)
      evt.cap_evt = 1'b0; // (R20)
    else if (evt.rise)
      evt.cap_evt = lvl & ~prev_q; // (R25)
    else
      evt.cap_evt = ~lvl & prev_q;
  end

  a_filt_agree: assert property (@(posedge i_clk) disable iff (i_rst) // (R18)
    (filt_q != $past(filt_q)) |-> ($past({smp_q, src}) == {4{filt_q}}))
    else $error("filter output changed without four equal samples");
endmodule // tcic_capfilt
`default_nettype wire

// ==== rtl/tcic_evt_if.sv ====
// Tick and capture event signals between the timer core and its front ends
`default_nettype none
interface tcic_evt_if;
  logic tick;
  logic cap_evt;
  logic filt_en;
  logic rise;
  logic armed;
  modport tick_src (output tick);
  modport cap_src  (input filt_en, input rise, input armed, output cap_evt);
  modport core     (input tick, input cap_evt, output filt_en, output rise, output armed);
endinterface // tcic_evt_if
`default_nettype wire

// ==== rtl/tcic_params.svh ====
// Register map, field positions, reset values and timing of the timer counter
// Overview of operation
// (R1) Clock select zero stops the counter
// (R2) Counter readable and writable at any time
// (R3) CPU write beats clear or count
// (R4) High location reaches only the shared latch
// (R5) Low read latches high; low write loads
// (R6) Each tick clears or steps by one
// (R7) Flag reached_a at zero, top at top
// (R8) Mode joins two bits of each control
// (R9) Overflow flag set where mode says
// (R10) Qualifying edge copies counter into capture
// (R11) Capture flag set with the copy
// (R12) Capture flag interrupts, clears on ack/one
// (R13) Capture read: low first, then latch
// (R14) Capture writable only in capture-top modes
// (R15) Software writes capture high before low
// (R16) Select bit swaps pin for comparator
// (R17) Filter adds four system clock cycles
// (R18) Filter changes only on four equal samples
// (R19) Filter enabled by control B bit
// (R20) Capture path off in capture-top modes
// (R21) Each event overwrites the capture value
// (R22) Port drive on capture pin can trigger
// (R23) One latch shared by all wide registers
// (R24) Tick from prescaler or external pin edge
// (R25) Edge select picks rising or falling
// (R26) Reset clears flags and capture value
`ifndef TCIC_PARAMS_SVH
`define TCIC_PARAMS_SVH
// =====================================================================
// Register addresses
`define TCIC_A_CNT_LO    3'h0
`define TCIC_A_CNT_HI    3'h1
`define TCIC_A_CAP_LO    3'h2
`define TCIC_A_CAP_HI    3'h3
`define TCIC_A_CTRL_A    3'h4
`define TCIC_A_CTRL_B    3'h5
`define TCIC_A_FLAG      3'h6
`define TCIC_A_MASK      3'h7
// =====================================================================
// Field positions and reset values
`define TCIC_A_WGM_LO    1:0
`define TCIC_B_CS        2:0
`define TCIC_B_WGM_HI    4:3
`define TCIC_B_EDGE      6
`define TCIC_B_FILT      7
`define TCIC_F_OVF       0
`define TCIC_F_CAP       5
`define TCIC_RST_BYTE    8'h00
`define TCIC_RST_WORD    16'h0000
`define TCIC_MAX         16'hffff
// =====================================================================
// Clock selects and waveform modes
`define TCIC_CS_STOP     3'h0
`define TCIC_CS_SYS      3'h1
`define TCIC_CS_EXT_FALL 3'h6
`define TCIC_CS_EXT_RISE 3'h7
`define TCIC_WGM_PFC_ICR 4'h8
`define TCIC_WGM_PC_ICR  4'ha
`define TCIC_WGM_CTC_ICR 4'hc
`define TCIC_WGM_FST_ICR 4'he
`define TCIC_FILT_SMP    4
`endif

// ==== rtl/tcic_pkg.sv ====
// Types shared by the timer counter modules
`default_nettype none
package tcic_pkg;
  typedef logic [7:0]  tcic_byte_t;
  typedef logic [15:0] tcic_word_t;
  typedef enum logic [1:0]
  {
    TCIC_UP   = 2'b01,
    TCIC_DOWN = 2'b10
  } tcic_dir_e;
endpackage // tcic_pkg
`default_nettype wire

// ==== rtl/tcic_tick.sv ====
// Timer tick source: prescaler taps or synchronised external clock pin
`default_nettype none
`include "tcic_params.svh"
module tcic_tick
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_clk_sel,
  input  wire logic [3:0] i_presc_tick,
  input  wire logic       i_ext_pin,
  tcic_evt_if.tick_src    evt
);
  logic [1:0] ext_sync_q;
  logic       ext_prev_q;

  // =====================================================================
  // External pin synchroniser and edge history
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[0], i_ext_pin};
      ext_prev_q <= ext_sync_q[1];
    end
  end

  // =====================================================================
  // Tick selection
  always_comb
  begin
    case (i_clk_sel)
      `TCIC_CS_STOP:     evt.tick = 1'b0; // (R1)
      `TCIC_CS_SYS:      evt.tick = 1'b1;
      `TCIC_CS_EXT_FALL: evt.tick = ext_prev_q & ~ext_sync_q[1]; // (R24)
      `TCIC_CS_EXT_RISE: evt.tick = ~ext_prev_q & ext_sync_q[1];
      default:           evt.tick = i_presc_tick[2'(i_clk_sel - 3'h2)]; // (R24)
    endcase
  end
endmodule // tcic_tick
`default_nettype wire

// ==== rtl/tcic_top.sv ====
// Sixteen-bit timer counter with input capture and byte-wide register access
`default_nettype none
`include "tcic_params.svh"
module tcic_top
(
  input  wire logic       I_SYS_CLK,
  input  wire logic       I_RST,
  input  wire logic [2:0] I_ADDR,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic [7:0] I_WDATA,
  output logic      [7:0] O_RDATA,
  input  wire logic [3:0] I_PRESC_TICK,
  input  wire logic       I_EXT_CLK_PIN,
  input  wire logic       I_CAP_PIN,
  input  wire logic       I_CAP_PORT_OUT,
  input  wire logic       I_CAP_PORT_OE,
  input  wire logic       I_CMP_OUT,
  input  wire logic       I_CMP_CAPTURE_SEL,
  input  wire logic       I_OVF_IRQ_ACK,
  input  wire logic       I_CAP_IRQ_ACK,
  output logic            O_OVF_IRQ,
  output logic            O_CAP_IRQ,
  output logic            O_AT_TOP,
  output logic            O_AT_REACHED_A
);
  tcic_pkg::tcic_byte_t ctrl_a_q;
  tcic_pkg::tcic_byte_t ctrl_b_q;
  tcic_pkg::tcic_byte_t mask_q;
  tcic_pkg::tcic_byte_t temp_q;
  tcic_pkg::tcic_byte_t rdata_q;
  tcic_pkg::tcic_byte_t rdata_d;
  tcic_pkg::tcic_word_t cnt_q;
  tcic_pkg::tcic_word_t cnt_d;
  tcic_pkg::tcic_word_t cap_q;
  tcic_pkg::tcic_word_t top_w;
  tcic_pkg::tcic_dir_e  dir_q;
  tcic_pkg::tcic_dir_e  dir_d;
  logic                 ovf_q;
  logic                 capf_q;
  logic [3:0]           mode;
  logic                 icr_mode;
  logic                 at_top;
  logic                 at_bot;
  logic                 tick;
  logic                 cap_evt;
  logic                 ovf_evt;
  logic                 wr_cnt_lo;
  logic                 wr_cap_lo;
  logic                 wr_hi;
  logic                 rd_cnt_lo;
  logic                 rd_cap_lo;
  logic                 ovf_clr;
  logic                 cap_clr;
  logic                 pin_lvl;

  // =====================================================================
  // Mode and access decoding
  function automatic logic is_icr_top(input logic [3:0] m);
    is_icr_top = (m == `TCIC_WGM_PFC_ICR) || (m == `TCIC_WGM_PC_ICR) ||
                 (m == `TCIC_WGM_CTC_ICR) || (m == `TCIC_WGM_FST_ICR);
  endfunction

  function automatic logic is_dual(input logic [3:0] m);
    is_dual = (m == `TCIC_WGM_PFC_ICR) || (m == `TCIC_WGM_PC_ICR);
  endfunction

  function automatic logic is_clr_top(input logic [3:0] m);
    is_clr_top = (m == `TCIC_WGM_CTC_ICR) || (m == `TCIC_WGM_FST_ICR);
  endfunction

  function automatic logic hit(input logic s, input logic [2:0] a, input logic [2:0] r);
    hit = s && (a == r);
  endfunction

  assign mode      = {ctrl_b_q[`TCIC_B_WGM_HI], ctrl_a_q[`TCIC_A_WGM_LO]}; // (R8)
  assign icr_mode  = is_icr_top(mode);
  assign top_w     = icr_mode ? cap_q : `TCIC_MAX;
  assign at_top    = (cnt_q == top_w); // (R7)
  assign at_bot    = (cnt_q == `TCIC_RST_WORD); // (R7)
  assign wr_cnt_lo = hit(I_WR, I_ADDR, `TCIC_A_CNT_LO);
  assign wr_cap_lo = hit(I_WR, I_ADDR, `TCIC_A_CAP_LO);
  assign wr_hi     = hit(I_WR, I_ADDR, `TCIC_A_CNT_HI) ||
                     hit(I_WR, I_ADDR, `TCIC_A_CAP_HI); // (R4)
  assign rd_cnt_lo = hit(I_RD, I_ADDR, `TCIC_A_CNT_LO);
  assign rd_cap_lo = hit(I_RD, I_ADDR, `TCIC_A_CAP_LO);
  assign ovf_clr   = I_OVF_IRQ_ACK ||
                     (hit(I_WR, I_ADDR, `TCIC_A_FLAG) && I_WDATA[`TCIC_F_OVF]);
  assign cap_clr   = I_CAP_IRQ_ACK ||
                     (hit(I_WR, I_ADDR, `TCIC_A_FLAG) && I_WDATA[`TCIC_F_CAP]); // (R12)
  assign pin_lvl   = I_CAP_PORT_OE ? I_CAP_PORT_OUT : I_CAP_PIN; // (R22)

  // =====================================================================
  // Tick source and capture trigger path
  tcic_evt_if u_evt ();

  assign u_evt.filt_en = ctrl_b_q[`TCIC_B_FILT]; // (R19)
  assign u_evt.rise    = ctrl_b_q[`TCIC_B_EDGE]; // (R25)
  assign u_evt.armed   = ~icr_mode; // (R20)
  assign tick          = u_evt.tick;
  assign cap_evt       = u_evt.cap_evt;

  tcic_tick u_tick
  (
    .i_clk        (I_SYS_CLK),
    .i_rst        (I_RST),
    .i_clk_sel    (ctrl_b_q[`TCIC_B_CS]),
    .i_presc_tick (I_PRESC_TICK),
    .i_ext_pin    (I_EXT_CLK_PIN),
    .evt          (u_evt.tick_src)
  );

  tcic_capfilt u_capfilt
  (
    .i_clk     (I_SYS_CLK),
    .i_rst     (I_RST),
    .i_pin     (pin_lvl),
    .i_cmp     (I_CMP_OUT),
    .i_cmp_sel (I_CMP_CAPTURE_SEL),
    .evt       (u_evt.cap_src)
  );

  // =====================================================================
  // Control registers
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      ctrl_a_q <= `TCIC_RST_BYTE;
      ctrl_b_q <= `TCIC_RST_BYTE;
      mask_q   <= `TCIC_RST_BYTE;
    end
    else
    begin
      if (hit(I_WR, I_ADDR, `TCIC_A_CTRL_A))
        ctrl_a_q <= I_WDATA;
      if (hit(I_WR, I_ADDR, `TCIC_A_CTRL_B))
        ctrl_b_q <= I_WDATA;
      if (hit(I_WR, I_ADDR, `TCIC_A_MASK))
        mask_q <= I_WDATA;
    end
  end

  // =====================================================================
  // Shared high-byte latch
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      temp_q <= `TCIC_RST_BYTE;
    else if (wr_hi)
      temp_q <= I_WDATA; // (R4) (R23)
    else if (rd_cnt_lo)
      temp_q <= cnt_q[15:8]; // (R5)
    else if (rd_cap_lo)
      temp_q <= cap_q[15:8]; // (R13)
  end

  // =====================================================================
  // Counter next value and direction
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (wr_cnt_lo)
      cnt_d = {temp_q, I_WDATA}; // (R2) (R3) (R5)
    else if (tick)
    begin
      if (is_dual(mode))
      begin
        case (dir_q)
          tcic_pkg::TCIC_UP:
          begin
            if (at_top)
            begin
              dir_d = tcic_pkg::TCIC_DOWN;
              cnt_d = cnt_q - 16'h0001; // (R6)
            end
            else
              cnt_d = cnt_q + 16'h0001;
          end
          tcic_pkg::TCIC_DOWN:
          begin
            if (at_bot)
            begin
              dir_d = tcic_pkg::TCIC_UP;
              cnt_d = cnt_q + 16'h0001;
            end
            else
              cnt_d = cnt_q - 16'h0001; // (R6)
          end
          default:
            dir_d = tcic_pkg::TCIC_UP;
        endcase
      end
      else
      begin
        dir_d = tcic_pkg::TCIC_UP;
        if (is_clr_top(mode) && at_top)
          cnt_d = `TCIC_RST_WORD; // (R6)
        else
          cnt_d = cnt_q + 16'h0001; // (R6)
      end
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      cnt_q <= `TCIC_RST_WORD;
      dir_q <= tcic_pkg::TCIC_UP;
    end
    else
    begin
      cnt_q <= cnt_d; // (R1)
      dir_q <= dir_d;
    end
  end

  // =====================================================================
  // Overflow flag
  always_comb
  begin
    if (!tick || wr_cnt_lo)
      ovf_evt = 1'b0;
    else if (is_dual(mode))
      ovf_evt = (dir_q == tcic_pkg::TCIC_DOWN) && at_bot; // (R9)
    else if (mode == `TCIC_WGM_FST_ICR)
      ovf_evt = at_top; // (R9)
    else
      ovf_evt = (cnt_q == `TCIC_MAX); // (R9)
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      ovf_q <= 1'b0; // (R26)
    else
      ovf_q <= ovf_evt || (ovf_q && !ovf_clr); // (R9)
  end

  // =====================================================================
  // Capture register and capture flag
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      cap_q <= `TCIC_RST_WORD; // (R26)
    else if (cap_evt)
      cap_q <= cnt_q; // (R10) (R21)
    else if (wr_cap_lo && icr_mode)
      cap_q <= {temp_q, I_WDATA}; // (R14)
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      capf_q <= 1'b0; // (R26)
    else
      capf_q <= cap_evt || (capf_q && !cap_clr); // (R11) (R12)
  end

  // =====================================================================
  // Read path
  always_comb
  begin
    case (I_ADDR)
      `TCIC_A_CNT_LO: rdata_d = cnt_q[7:0]; // (R2)
      `TCIC_A_CNT_HI: rdata_d = temp_q; // (R4)
      `TCIC_A_CAP_LO: rdata_d = cap_q[7:0];
      `TCIC_A_CAP_HI: rdata_d = temp_q; // (R13)
      `TCIC_A_CTRL_A: rdata_d = ctrl_a_q;
      `TCIC_A_CTRL_B: rdata_d = ctrl_b_q;
      `TCIC_A_FLAG:   rdata_d = {2'h0, capf_q, 4'h0, ovf_q};
      default:        rdata_d = mask_q;
    endcase
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      rdata_q <= `TCIC_RST_BYTE;
    else if (I_RD)
      rdata_q <= rdata_d;
  end

  assign O_RDATA     = rdata_q;
  assign O_OVF_IRQ   = ovf_q && mask_q[`TCIC_F_OVF];
  assign O_CAP_IRQ   = capf_q && mask_q[`TCIC_F_CAP]; // (R12)
  assign O_AT_TOP    = at_top;
  assign O_AT_REACHED_A = at_bot;

  // =====================================================================
  // Checks
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);

  a_stop_holds: assert property ( // (R1)
    (ctrl_b_q[`TCIC_B_CS] == `TCIC_CS_STOP && !wr_cnt_lo) |=> $stable(cnt_q))
    else $error("counter moved with no clock source");

  a_cpu_write_wins: assert property ( // (R3)
    wr_cnt_lo |=> (cnt_q == {$past(temp_q), $past(I_WDATA)}))
    else $error("counter write lost to a count or clear");

  a_latch_on_read: assert property ( // (R5)
    (rd_cnt_lo && !I_WR) ##1 (!I_RD && !I_WR)
      ##1 (I_RD && I_ADDR == `TCIC_A_CNT_HI && !I_WR)
      |=> (O_RDATA == $past(cnt_q[15:8], 3)))
    else $error("high read did not return latched counter byte");

  a_normal_step: assert property ( // (R6)
    (tick && !wr_cnt_lo && mode == 4'h0) |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("normal mode did not step by one");

  a_dual_turn: assert property ( // (R7)
    (tick && !wr_cnt_lo && is_dual(mode) && at_top && cnt_q != 16'h0000)
      |=> (dir_q == tcic_pkg::TCIC_DOWN))
    else $error("dual slope did not turn at top");

  a_ovf_set: assert property ( // (R9)
    ovf_evt |=> ovf_q ##0 (ovf_q || ovf_clr)[*1])
    else $error("overflow event did not set the flag");

  a_capture_copy: assert property ( // (R11)
    cap_evt |=> (cap_q == $past(cnt_q)) && capf_q)
    else $error("capture copy and flag not in the same cycle");

  a_capture_clear: assert property ( // (R12)
    (I_CAP_IRQ_ACK && !cap_evt) |=> !capf_q)
    else $error("acknowledge did not clear the capture flag");

  a_cap_write_gate: assert property ( // (R14)
    (wr_cap_lo && !icr_mode && !cap_evt) |=> $stable(cap_q))
    else $error("capture value written outside a capture-top mode");

  a_no_cap_in_top: assert property ( // (R20)
    icr_mode |-> !cap_evt)
    else $error("capture event while capture defines top");

  a_reset_clear: assert property (disable iff (1'b0) // (R26)
    I_RST |=> (cap_q == 16'h0000) && !ovf_q && !capf_q)
    else $error("reset left flags or capture value set");

  c_capture:   cover property (cap_evt ##1 capf_q);
  c_overflow:  cover property (ovf_evt ##1 O_OVF_IRQ);
  c_dual_turn: cover property (dir_q == tcic_pkg::TCIC_DOWN ##[1:300] dir_q == tcic_pkg::TCIC_UP);
  c_set_clear: cover property (cap_evt && cap_clr);
endmodule // tcic_top
`default_nettype wire
